// ===== logic/smo_pkg.sv
// Purpose: constants for the status monitor output multiplexer
// Assumes: pclk at 10 MHz, APB registers at aligned byte offsets
// Notes: pulse widths are derived from nanosecond figures
// Overview of operation
// R1 - overflow group: outputs 7..1 follow each Tx/Rx filter stage overflow
// R2 - cal/state group: outputs 7..4 carry calibration sequencer state
// R3 - cal/state group: outputs 3..0 carry radio state machine state
// R4 - peak detector reset indicator on output 6 of one group, 4 of another
// R5 - gain freeze indicator high when freeze bits hold a locked gain
// R6 - digital saturation latches, clears on gain change, masked in reset
// R7 - Tx quadrature group outputs 7..6 show 2-bit calibration state
// R8 - single high pulse near 480 ns when quadrature calibration finishes; here 4 pclk cycles, 400 ns
// R9 - output 4 high while RF DC calibration runs
// R10 - baseband DC busy high for baseband and again for RF DC calibration
// R11 - second gain group: AGC state, peak reset, RF DC cal state
// R12 - output 3 high while the RSSI word is valid
// R13 - outputs 7..0 present auxiliary ADC result bits 11..4
// R14 - output 7 pulses near 65 ns on each filter power word; here one pclk cycle, 100 ns
// R15 - output 3 pulses per ADC power word when ADC power feeds AGC
// R16 - signal present: manual high, slow/hybrid 400 ns dip, fast waits lock
// R17 - short pulse near 30 ns on each RF offset word update; here one pclk cycle, 100 ns
// R18 - RF offset measuring flag forced low during gain change
// R19 - pulse near 30 ns whenever offset tracking count is reached; here one pclk cycle, 100 ns
// R20 - gain index group: output 7 gain lock, 6..0 Rx gain index
// R21 - decimated power valid: manual high, dips about 400 ns on gain change
// R22 - charge pump group outputs 7..4 show Rx charge pump cal state
// R23 - baseband processor enables the output pins before they show data
// R24 - selector picks the group; undefined bits held low
package smo_pkg;
    localparam logic [11:0] ADDR_SEL    = 12'h000;
    localparam logic [11:0] ADDR_PIN_EN = 12'h004;
    localparam logic [11:0] ADDR_OUTS   = 12'h008;
    localparam logic [7:0]  SEL_RESET   = 8'h00;
    localparam logic [7:0]  PIN_EN_RESET = 8'h00;

    localparam logic [7:0] GRP_OVF   = 8'h0a;
    localparam logic [7:0] GRP_CAL   = 8'h0b;
    localparam logic [7:0] GRP_GAIN1 = 8'h0c;
    localparam logic [7:0] GRP_QUAD  = 8'h0d;
    localparam logic [7:0] GRP_BBDC  = 8'h0e;
    localparam logic [7:0] GRP_GAIN2 = 8'h0f;
    localparam logic [7:0] GRP_RSSI  = 8'h10;
    localparam logic [7:0] GRP_AUX   = 8'h11;
    localparam logic [7:0] GRP_PWR   = 8'h12;
    localparam logic [7:0] GRP_DCTRK = 8'h15;
    localparam logic [7:0] GRP_GIDX  = 8'h16;
    localparam logic [7:0] GRP_DECP  = 8'h18;
    localparam logic [7:0] GRP_CP    = 8'h19;

    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_SLOW   = 2'h1;
    localparam logic [1:0] MODE_HYBRID = 2'h2;
    localparam logic [1:0] MODE_FAST   = 2'h3;

    localparam int CLK_MHZ      = 10;
    localparam int QDONE_NS     = 480;
    localparam int FPWR_NS      = 65;
    localparam int OFFS_NS      = 30;
    localparam int GAIN_DIP_NS  = 400;

    function automatic logic [3:0] ns_to_cyc(input int ns);
        int c;
        c = ns * CLK_MHZ / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c[3:0];
    endfunction : ns_to_cyc

    localparam logic [3:0] QDONE_CYC = ns_to_cyc(QDONE_NS);
    localparam logic [3:0] FPWR_CYC  = ns_to_cyc(FPWR_NS);
    localparam logic [3:0] OFFS_CYC  = ns_to_cyc(OFFS_NS);
    localparam logic [3:0] DIP_CYC   = ns_to_cyc(GAIN_DIP_NS);

    localparam int NPULSE  = 8;
    localparam int P_QDONE = 0;
    localparam int P_FPWR  = 1;
    localparam int P_APWR  = 2;
    localparam int P_OUPD  = 3;
    localparam int P_TRK   = 4;
    localparam int P_SPDIP = 5;
    localparam int P_DPDIP = 6;
    localparam int P_APWR2 = 7;
endpackage : smo_pkg

// ===== logic/smo_pulse.sv
// Purpose: per-channel one-shot pulse generators
// Assumes: triggers are single-cycle pulses on pclk
// Notes: a retrigger restarts the count
`timescale 1ns/100ps
`default_nettype none
module smo_pulse #(
    parameter int                N     = 8,
    parameter logic [N*4-1:0]    WIDTH = '0
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [N-1:0]  trig,
    output logic      [N-1:0]  pulse
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            logic [3:0] cnt_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q <= 4'h0;
                end else if (trig[i]) begin
                    cnt_q <= WIDTH[i*4 +: 4];
                end else if (cnt_q != 4'h0) begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
            assign pulse[i] = (cnt_q != 4'h0);
        end
    endgenerate
endmodule : smo_pulse
`default_nettype wire

// ===== logic/smo_top.sv
// Purpose: routes internal status groups onto eight control output pins
// Assumes: status inputs are on pclk except ctrl_in2, a pin
// Notes: one cycle from mux_d to pin, pins gated by enable register
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module smo_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [6:0]  stage_ovf,
    input  wire logic [3:0]  cal_seq_state,
    input  wire logic [3:0]  radio_state_machine,
    input  wire logic        energy_lost,
    input  wire logic        pkd_reset,
    input  wire logic        freeze_bits,
    input  wire logic        gain_lock,
    input  wire logic        dig_overload,
    input  wire logic        gain_change,
    input  wire logic        gain_changing,
    input  wire logic [1:0]  tx_quad_cal_state,
    input  wire logic        tx_quad_cal_fin,
    input  wire logic        rf_dc_cal_busy,
    input  wire logic        bb_dc_cal_busy,
    input  wire logic [2:0]  agc_state,
    input  wire logic [1:0]  rf_dc_cal_state,
    input  wire logic        rssi_valid,
    input  wire logic [11:0] aux_adc_word,
    input  wire logic        filt_pwr_evt,
    input  wire logic        adc_pwr_evt,
    input  wire logic        adc_pwr_agc_src,
    input  wire logic        adc_pwr2_evt,
    input  wire logic        stronger_signal,
    input  wire logic [1:0]  gain_mode,
    input  wire logic        gain_upd_expire,
    input  wire logic        ctrl_in2,
    input  wire logic        dig_pwr_above,
    input  wire logic        offset_word_upd,
    input  wire logic        offset_calc,
    input  wire logic        track_count_evt,
    input  wire logic [6:0]  rx_gain_index,
    input  wire logic        dec_pwr_valid,
    input  wire logic [3:0]  rx_charge_pump_cal_state,
    output logic      [7:0]  ctrl_out
);
    logic [7:0] sel_q;
    logic [7:0] pin_en_q;
    logic [7:0] mux_d;
    logic [7:0] out_q;
    logic       sat_q;
    logic       freeze_q;
    logic       in2_s1_q;
    logic       in2_s2_q;
    logic       in2_s3_q;
    logic       in2_rise;
    logic [smo_pkg::NPULSE-1:0] trig;
    logic [smo_pkg::NPULSE-1:0] pulse;
    logic       sig_present;
    logic       dec_valid;
    logic       rf_offset_measuring_flag;
    logic       wr_en;
    logic       rd_setup;
    logic       addr_ok;

    // apb slave, zero wait states
    assign pready  = 1'b1;
    assign addr_ok = (paddr == smo_pkg::ADDR_SEL) ||
                     (paddr == smo_pkg::ADDR_PIN_EN) ||
                     (paddr == smo_pkg::ADDR_OUTS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= smo_pkg::SEL_RESET;
        end else if (wr_en && paddr == smo_pkg::ADDR_SEL) begin
            sel_q <= pwdata[7:0]; // R24
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_en_q <= smo_pkg::PIN_EN_RESET;
        end else if (wr_en && paddr == smo_pkg::ADDR_PIN_EN) begin
            pin_en_q <= pwdata[7:0]; // R23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (paddr)
                smo_pkg::ADDR_SEL:    prdata <= {24'h00_0000, sel_q};
                smo_pkg::ADDR_PIN_EN: prdata <= {24'h00_0000, pin_en_q};
                smo_pkg::ADDR_OUTS:   prdata <= {24'h00_0000, out_q};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

    // hybrid gain update input comes from a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in2_s1_q <= 1'b0;
            in2_s2_q <= 1'b0;
            in2_s3_q <= 1'b0;
        end else begin
            in2_s1_q <= ctrl_in2;
            in2_s2_q <= in2_s1_q;
            in2_s3_q <= in2_s2_q;
        end
    end
    assign in2_rise = in2_s2_q && !in2_s3_q;

    // digital saturation: set wins, masked while detectors held in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_q <= 1'b0;
        end else if (dig_overload && !pkd_reset) begin
            sat_q <= 1'b1; // R6
        end else if (gain_change) begin
            sat_q <= 1'b0; // R6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_q <= 1'b0;
        end else begin
            freeze_q <= freeze_bits && gain_lock; // R5
        end
    end

    assign trig[smo_pkg::P_QDONE] = tx_quad_cal_fin; // R8
    assign trig[smo_pkg::P_FPWR]  = filt_pwr_evt; // R14
    assign trig[smo_pkg::P_APWR]  = adc_pwr_evt && adc_pwr_agc_src; // R15
    assign trig[smo_pkg::P_OUPD]  = offset_word_upd; // R17
    assign trig[smo_pkg::P_TRK]   = track_count_evt; // R19
    assign trig[smo_pkg::P_SPDIP] =
        (gain_mode == smo_pkg::MODE_SLOW && gain_upd_expire) ||
        (gain_mode == smo_pkg::MODE_HYBRID && in2_rise); // R16
    assign trig[smo_pkg::P_DPDIP] = gain_change; // R21
    assign trig[smo_pkg::P_APWR2] = adc_pwr2_evt;

    smo_pulse #(
        .N     (smo_pkg::NPULSE),
        .WIDTH ({smo_pkg::FPWR_CYC, smo_pkg::DIP_CYC, smo_pkg::DIP_CYC,
                 smo_pkg::OFFS_CYC, smo_pkg::OFFS_CYC, smo_pkg::FPWR_CYC,
                 smo_pkg::FPWR_CYC, smo_pkg::QDONE_CYC})
    ) u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (trig),
        .pulse   (pulse)
    );

    always_comb begin
        if (gain_mode == smo_pkg::MODE_MANUAL) begin
            sig_present = 1'b1; // R16
        end else if (gain_mode == smo_pkg::MODE_FAST) begin
            sig_present = gain_lock && dig_pwr_above; // R16
        end else begin
            sig_present = dig_pwr_above && !pulse[smo_pkg::P_SPDIP]; // R16
        end
    end

    assign dec_valid = (gain_mode == smo_pkg::MODE_MANUAL) ||
                       (dec_pwr_valid && !pulse[smo_pkg::P_DPDIP]); // R21
    assign rf_offset_measuring_flag = offset_calc && !gain_changing; // R18

    // group selection, unused bits low
    always_comb begin
        mux_d = 8'h00;
        unique case (sel_q)
            smo_pkg::GRP_OVF: mux_d = {stage_ovf, 1'b0}; // R1
            smo_pkg::GRP_CAL: mux_d = {cal_seq_state,
                                       radio_state_machine}; // R2 R3
            smo_pkg::GRP_GAIN1: mux_d = {energy_lost, pkd_reset, 2'b00,
                                         freeze_q, sat_q, 2'b00}; // R4 R5
            smo_pkg::GRP_QUAD: mux_d = {tx_quad_cal_state,
                                        pulse[smo_pkg::P_QDONE],
                                        rf_dc_cal_busy, 4'h0}; // R7 R9
            smo_pkg::GRP_BBDC: mux_d = {3'b000,
                                        bb_dc_cal_busy || rf_dc_cal_busy,
                                        4'h0}; // R10
            smo_pkg::GRP_GAIN2: mux_d = {agc_state, pkd_reset, 1'b0,
                                         rf_dc_cal_state, 1'b0}; // R11
            smo_pkg::GRP_RSSI: mux_d = {4'h0, rssi_valid, 3'b000}; // R12
            smo_pkg::GRP_AUX: mux_d = aux_adc_word[11:4]; // R13
            smo_pkg::GRP_PWR: mux_d = {pulse[smo_pkg::P_FPWR], gain_lock,
                                       energy_lost, stronger_signal,
                                       pulse[smo_pkg::P_APWR],
                                       agc_state}; // R14 R15
            smo_pkg::GRP_DCTRK: mux_d = {sig_present,
                                         pulse[smo_pkg::P_OUPD],
                                         rf_offset_measuring_flag,
                                         pulse[smo_pkg::P_TRK],
                                         4'h0}; // R16 R17 R18 R19
            smo_pkg::GRP_GIDX: mux_d = {gain_lock, rx_gain_index}; // R20
            smo_pkg::GRP_DECP: mux_d = {6'h00, dec_valid,
                                        pulse[smo_pkg::P_APWR2]}; // R21
            smo_pkg::GRP_CP: mux_d = {rx_charge_pump_cal_state,
                                      4'h0}; // R22
            default: mux_d = 8'h00; // R24
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 8'h00;
        end else begin
            out_q <= mux_d & pin_en_q; // R24
        end
    end
    assign ctrl_out = out_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic all_on;
    assign all_on = (pin_en_q == 8'hff);

    sequence qdone_pulse_s;
        pulse[smo_pkg::P_QDONE] [*4];
    endsequence

    sequence trk_pulse_s;
        pulse[smo_pkg::P_TRK] ##1 !pulse[smo_pkg::P_TRK];
    endsequence

    ovf_route_a: assert property ( // R1
        (sel_q == smo_pkg::GRP_OVF && all_on && $stable(sel_q))
        |=> ctrl_out == {$past(stage_ovf), 1'b0})
        else $error("overflow group not routed");

    cal_route_a: assert property ( // R2
        (sel_q == smo_pkg::GRP_CAL && all_on)
        |=> ctrl_out == {$past(cal_seq_state), $past(radio_state_machine)})
        else $error("calibration state group not routed");

    freeze_lock_a: assert property ( // R5
        freeze_q |-> $past(gain_lock) && $past(freeze_bits))
        else $error("freeze shown without locked gain");

    sat_hold_a: assert property ( // R6
        (pkd_reset && !sat_q) |=> !sat_q)
        else $error("saturation set while peak reset held");

    sat_clear_a: assert property ( // R6
        (gain_change && sat_q && !dig_overload) |=> !sat_q)
        else $error("saturation not cleared by gain change");

    qdone_width_a: assert property ( // R8
        tx_quad_cal_fin |=> qdone_pulse_s)
        else $error("quadrature done pulse too short");

    qdone_len_a: assert property ( // R8
        (tx_quad_cal_fin && !pulse[smo_pkg::P_QDONE])
        ##1 (!tx_quad_cal_fin [*5]) |-> $past(pulse[smo_pkg::P_QDONE], 2)
        && !pulse[smo_pkg::P_QDONE])
        else $error("quadrature done pulse width wrong");

    trk_pulse_a: assert property ( // R19
        track_count_evt ##1 !track_count_evt |-> trk_pulse_s)
        else $error("tracking count pulse wrong");

    meas_gate_a: assert property ( // R18
        gain_changing |-> !rf_offset_measuring_flag)
        else $error("measuring shown during gain change");

    sigp_manual_a: assert property ( // R16
        (gain_mode == smo_pkg::MODE_MANUAL && sel_q == smo_pkg::GRP_DCTRK
         && all_on && $stable(sel_q)) |=> ctrl_out[7])
        else $error("signal present low in manual mode");

    sigp_dip_a: assert property ( // R16
        (gain_mode == smo_pkg::MODE_SLOW && gain_upd_expire
         && $stable(gain_mode)) |=> !sig_present [*4])
        else $error("signal present dip too short");

    bbdc_busy_a: assert property ( // R10
        (sel_q == smo_pkg::GRP_BBDC && all_on && $stable(sel_q)
         && rf_dc_cal_busy) |=> ctrl_out[4])
        else $error("baseband busy not raised for RF calibration");

    undef_low_a: assert property ( // R24
        (sel_q == smo_pkg::GRP_RSSI && $stable(sel_q))
        |=> (ctrl_out & 8'hf7) == 8'h00)
        else $error("undefined output bit driven");

    rssi_route_a: assert property ( // R12
        (sel_q == smo_pkg::GRP_RSSI && all_on && $stable(sel_q))
        |=> ctrl_out[3] == $past(rssi_valid))
        else $error("rssi valid not routed");

    aux_route_a: assert property ( // R13
        (sel_q == smo_pkg::GRP_AUX && all_on)
        |=> ctrl_out == $past(aux_adc_word[11:4]))
        else $error("auxiliary converter bits not routed");

    gidx_route_a: assert property ( // R20
        (sel_q == smo_pkg::GRP_GIDX && all_on)
        |=> ctrl_out == {$past(gain_lock), $past(rx_gain_index)})
        else $error("gain index group not routed");

    logic unused_ok;
    assign unused_ok = &{1'b0, pwdata[31:8]};
endmodule : smo_top
`default_nettype wire

// ===== tb/smo_bbp_model.sv
// Purpose: baseband processor side model, apb master of the monitor
// Assumes: pready sampled at rising edges of pclk
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module smo_bbp_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // one transfer: setup cycle, access held until pready
    task automatic apb_xfer(input logic wr, input logic [11:0] a,
                            input logic [31:0] wd, output logic [31:0] rd,
                            output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~wd;
    endtask : apb_xfer

    // pins must be enabled before status shows on them
    task automatic enable_pins(input logic [7:0] mask);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, smo_pkg::ADDR_PIN_EN, {24'h0, mask}, rd, err);
    endtask : enable_pins
endmodule : smo_bbp_model
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the status output multiplexer
// Assumes: zero wait state apb, one edge from mux_d to pin
// Notes: groups checked by table, pulses and dips counted per table row
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, aux_adc_word;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  trg = 9'h0;
    logic [7:0]  ctrl_out, n;
    logic [6:0]  stage_ovf, rx_gain_index;
    logic [3:0]  cal_seq_state, radio_state_machine, rx_charge_pump_cal_state;
    logic [2:0]  agc_state;
    logic [1:0]  tx_quad_cal_state, rf_dc_cal_state, gain_mode;
    logic        energy_lost, pkd_reset, freeze_bits, gain_lock, dig_overload;
    logic        gain_changing, rf_dc_cal_busy, bb_dc_cal_busy, rssi_valid;
    logic        adc_pwr_agc_src, stronger_signal, dig_pwr_above, er;
    logic        offset_calc, dec_pwr_valid;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    // {pattern, selector, expected pins}
    localparam logic [16:0] ROWS [28] = '{
        17'h00aaa, 17'h00b25, 17'h00c80, 17'h00d90, 17'h00e10, 17'h00fa2,
        17'h01008, 17'h011a5, 17'h01265, 17'h015a0, 17'h016ab, 17'h01802,
        17'h01980, 17'h01300, 17'h10a54, 17'h10bda, 17'h10c48, 17'h10d40,
        17'h10e10, 17'h10f54, 17'h11000, 17'h1115a, 17'h11252, 17'h11580,
        17'h116d4, 17'h11802, 17'h11910, 17'h1ff00};
    // {pattern, selector, trigger, pin, idle level, cycles off idle}
    localparam logic [27:0] PULSES [10] = '{
        28'h20d0504, 28'h2121701, 28'h2122301, 28'h2153601, 28'h2154401,
        28'h2155714, 28'h2186114, 28'h2187001, 28'h3158714, 28'h1122300};

    smo_top i_smo_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .stage_ovf, .cal_seq_state,
        .radio_state_machine, .energy_lost, .pkd_reset, .freeze_bits,
        .gain_lock, .dig_overload, .gain_change(trg[6]), .gain_changing,
        .tx_quad_cal_state, .tx_quad_cal_fin(trg[0]), .rf_dc_cal_busy,
        .bb_dc_cal_busy, .agc_state, .rf_dc_cal_state, .rssi_valid,
        .aux_adc_word, .filt_pwr_evt(trg[1]), .adc_pwr_evt(trg[2]),
        .adc_pwr_agc_src, .adc_pwr2_evt(trg[7]), .stronger_signal,
        .gain_mode, .gain_upd_expire(trg[5]), .ctrl_in2(trg[8]),
        .dig_pwr_above, .offset_word_upd(trg[3]), .offset_calc,
        .track_count_evt(trg[4]), .rx_gain_index, .dec_pwr_valid,
        .rx_charge_pump_cal_state, .ctrl_out);
    smo_bbp_model i_smo_bbp_model (.pclk, .pready, .prdata, .pslverr,
        .psel, .penable, .pwrite, .paddr, .pwdata);

    always #50 pclk = ~pclk;

    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic cmp_pins(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pins

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_smo_bbp_model.apb_xfer(1'b1, a, {24'h0, d}, rd, er);
    endtask : wr

    task automatic rdw(input logic [11:0] a);
        i_smo_bbp_model.apb_xfer(1'b0, a, 32'h0, rd, er);
    endtask : rdw

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    // 0: manual, 1: fast, 2: slow, 3: hybrid; bit 0 picks level set
    task automatic set_pat(input logic [3:0] p);
        {stage_ovf, cal_seq_state, radio_state_machine,
         rx_charge_pump_cal_state} <= p[0] ? {7'h2a, 4'hd, 4'ha, 4'h1}
                                           : {7'h55, 4'h2, 4'h5, 4'h8};
        {energy_lost, pkd_reset, freeze_bits, gain_lock, dig_overload,
         gain_changing, rf_dc_cal_busy, bb_dc_cal_busy, rssi_valid,
         adc_pwr_agc_src, stronger_signal, offset_calc}
            <= p[0] ? 12'h753 : 12'h92d;
        {tx_quad_cal_state, agc_state, rf_dc_cal_state, rx_gain_index,
         aux_adc_word} <= p[0] ? {2'h1, 3'h2, 2'h2, 7'h54, 12'h5a3}
                               : {2'h2, 3'h5, 2'h1, 7'h2b, 12'ha5c};
        gain_mode <= (p == 4'h1) ? smo_pkg::MODE_FAST :
                     (p == 4'h2) ? smo_pkg::MODE_SLOW :
                     (p == 4'h3) ? smo_pkg::MODE_HYBRID : smo_pkg::MODE_MANUAL;
        dig_pwr_above <= (p != 4'h0);
        dec_pwr_valid <= (p != 4'h0);
    endtask : set_pat

    initial begin
        set_pat(4'h0);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        cmp_pins(ctrl_out, 8'h00);
        rdw(smo_pkg::ADDR_SEL);
        cmp_word(rd, 32'h0);
        rdw(smo_pkg::ADDR_PIN_EN);
        cmp_word(rd, 32'h0);
        wr(12'h0fc, 8'h0b);
        cmp_pins({7'h0, er}, 8'h01);
        rdw(12'h0fc);
        cmp_pins({7'h0, er}, 8'h01);
        cmp_word(rd, 32'h0);
        rdw(smo_pkg::ADDR_SEL);
        cmp_word(rd, 32'h0);
        wr(smo_pkg::ADDR_SEL, 8'h0b);
        settle();
        cmp_pins(ctrl_out, 8'h00);
        i_smo_bbp_model.enable_pins(8'h0f);
        settle();
        cmp_pins(ctrl_out, 8'h05);
        i_smo_bbp_model.enable_pins(8'hff);
        foreach (ROWS[i]) begin
            @(posedge pclk);
            set_pat({3'h0, ROWS[i][16]});
            wr(smo_pkg::ADDR_SEL, ROWS[i][15:8]);
            settle();
            cmp_pins(ctrl_out, ROWS[i][7:0]);
            rdw(smo_pkg::ADDR_OUTS);
            cmp_word(rd, {24'h0, ROWS[i][7:0]});
        end
        foreach (PULSES[i]) begin
            @(posedge pclk);
            set_pat(PULSES[i][27:24]);
            wr(smo_pkg::ADDR_SEL, PULSES[i][23:16]);
            settle();
            @(posedge pclk);
            trg[PULSES[i][15:12]] <= 1'b1;
            @(posedge pclk);
            trg[PULSES[i][15:12]] <= 1'b0;
            n = 8'h00;
            repeat (12) begin
                @(posedge pclk);
                #1;
                if (ctrl_out[PULSES[i][10:8]] !== PULSES[i][4]) n = n + 8'h01;
            end
            cmp_pins(n, {4'h0, PULSES[i][3:0]});
        end
        @(posedge pclk);
        set_pat(4'h0);
        wr(smo_pkg::ADDR_SEL, 8'h0c);
        dig_overload <= 1'b1;
        @(posedge pclk);
        dig_overload <= 1'b0;
        settle();
        cmp_pins(ctrl_out, 8'h84);
        @(posedge pclk);
        trg[6] <= 1'b1;
        @(posedge pclk);
        trg[6] <= 1'b0;
        pkd_reset <= 1'b1;
        dig_overload <= 1'b1;
        settle();
        cmp_pins(ctrl_out, 8'hc0);
        @(posedge pclk);
        pkd_reset <= 1'b0;
        freeze_bits <= 1'b1;
        gain_lock <= 1'b0;
        settle();
        cmp_pins(ctrl_out, 8'h84);
        @(posedge pclk);
        gain_lock <= 1'b1;
        settle();
        cmp_pins(ctrl_out, 8'h8c);
        @(posedge pclk);
        gain_mode <= smo_pkg::MODE_FAST;
        gain_lock <= 1'b0;
        dig_pwr_above <= 1'b1;
        wr(smo_pkg::ADDR_SEL, 8'h15);
        settle();
        cmp_pins(ctrl_out, 8'h20);
        @(posedge pclk);
        gain_lock <= 1'b1;
        settle();
        cmp_pins(ctrl_out, 8'ha0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        cmp_pins(ctrl_out, 8'h00);
        rdw(smo_pkg::ADDR_PIN_EN);
        cmp_word(rd, 32'h0);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
